//--- inc/pio_defines.svh
// Purpose: offsets, reset values and fixed read values of the port block
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PIO_OFS_DATA_A  12'h000
`define PIO_OFS_DATA_B  12'h004
`define PIO_OFS_DATA_C  12'h008
`define PIO_OFS_DATA_D  12'h00C
`define PIO_OFS_DIR_A   12'h010
`define PIO_OFS_DIR_B   12'h014
`define PIO_OFS_DIR_C   12'h018

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define PIO_BYTE_LSB    0
`define PIO_BYTE_MSB    7
`define PIO_DIR_RST     8'h00
`define PIO_DIR_RDVAL   8'hFF
`define PIO_WORD_ZERO   32'h00000000

`endif

//--- inc/pio_pkg.sv
// Purpose: shared types of the parallel port block
// Assumes: included alongside pio_defines.svh
// Notes:   register select decoded from the apb address
package pio_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // one port byte
    typedef logic [7:0] pio_byte_t;

    // decoded register target
    typedef enum logic [2:0]
    {
        PIO_SEL_DATA_A,
        PIO_SEL_DATA_B,
        PIO_SEL_DATA_C,
        PIO_SEL_DATA_D,
        PIO_SEL_DIR_A,
        PIO_SEL_DIR_B,
        PIO_SEL_DIR_C,
        PIO_SEL_NONE
    } pio_sel_t;

endpackage : pio_pkg

//--- rtl/pio_port_block.sv
// Purpose: four 8-bit parallel ports, three bidirectional, one input only
// Assumes: apb3 slave, zero wait states, pins synchronous to pclk
// Notes:   output latches carry no reset, direction registers do
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pio_defines.svh"

// Operation
// R1: four 8-bit ports, three per-bit configurable
// R2: direction bit one output, zero input
// R3: reset clears all direction registers
// R4: reset leaves output latches untouched
// R5: port write updates all eight latch bits
// R6: output bit reads back its latch
// R7: input bit reads the pin level
// R8: direction registers read as all ones
// R9: fourth port input only, always readable
// R10: software loads latch before enabling outputs
// R11: software beware read-modify-write on mixed ports
// R12: input direction puts driver in high impedance
// R13: registers update and pins sampled on clock
// R14: output pins follow latch and direction
module pio_port_block
    import pio_pkg::*;
#(
    parameter int PORT_W = 8    // bits per port
)
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // first bidirectional port
    input  wire logic [PORT_W-1:0]  first_port_lines_in,
    output logic      [PORT_W-1:0]  first_port_lines_out,
    output logic      [PORT_W-1:0]  first_port_lines_oe,
    // second bidirectional port
    input  wire logic [PORT_W-1:0]  second_port_lines_in,
    output logic      [PORT_W-1:0]  second_port_lines_out,
    output logic      [PORT_W-1:0]  second_port_lines_oe,
    // third bidirectional port
    input  wire logic [PORT_W-1:0]  third_port_lines_in,
    output logic      [PORT_W-1:0]  third_port_lines_out,
    output logic      [PORT_W-1:0]  third_port_lines_oe,
    // input-only port
    input  wire logic [PORT_W-1:0]  input_only_port_lines
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // byte-wide registers only
    if (PORT_W != 8)
    begin : g_bad_width
        $error("pio_port_block: PORT_W must be 8");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int NBIDIR = 3;          // bidirectional ports

    pio_byte_t  dir_reg  [NBIDIR];      // direction, one = output
    pio_byte_t  dir_next [NBIDIR];      // next direction
    pio_byte_t  out_reg  [NBIDIR];      // output data latches
    pio_byte_t  out_next [NBIDIR];      // next latch value
    pio_byte_t  pin_in   [NBIDIR];      // pin levels per port
    pio_byte_t  rd_mix   [NBIDIR];      // per-bit read view
    logic [31:0] prdata_reg;            // read data register
    logic [31:0] prdata_next;           // next read data
    logic        pslverr_reg;           // error register
    logic        pslverr_next;          // next error
    pio_sel_t    sel;                   // decoded target
    logic        wr_en;                 // write access phase
    logic        rd_setup;              // read setup phase

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // writes take effect in the access phase, no wait states
    assign wr_en    = psel & penable & pwrite;
    // reads capture in the setup cycle so data is a flop
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;

    // address to register target
    always_comb
    begin
        case (paddr)
            `PIO_OFS_DATA_A: sel = PIO_SEL_DATA_A;
            `PIO_OFS_DATA_B: sel = PIO_SEL_DATA_B;
            `PIO_OFS_DATA_C: sel = PIO_SEL_DATA_C;
            `PIO_OFS_DATA_D: sel = PIO_SEL_DATA_D;
            `PIO_OFS_DIR_A:  sel = PIO_SEL_DIR_A;
            `PIO_OFS_DIR_B:  sel = PIO_SEL_DIR_B;
            `PIO_OFS_DIR_C:  sel = PIO_SEL_DIR_C;
            default:         sel = PIO_SEL_NONE;
        endcase
    end

    // gather pins so the port loop can index them
    assign pin_in[0] = first_port_lines_in;
    assign pin_in[1] = second_port_lines_in;
    assign pin_in[2] = third_port_lines_in;

    // ------------------------------------------------------------
    // bidirectional port slices
    // ------------------------------------------------------------
    for (genvar p = 0; p < NBIDIR; p++)                     // R1
    begin : g_port
        // next direction and latch for this port
        always_comb
        begin
            dir_next[p] = dir_reg[p];
            out_next[p] = out_reg[p];
            // whole byte loads regardless of direction
            if (wr_en && sel == pio_sel_t'(PIO_SEL_DATA_A + p))
            begin
                out_next[p] = pwdata[`PIO_BYTE_MSB:`PIO_BYTE_LSB]; // R5 R13
            end
            if (wr_en && sel == pio_sel_t'(PIO_SEL_DIR_A + p))
            begin
                dir_next[p] = pwdata[`PIO_BYTE_MSB:`PIO_BYTE_LSB]; // R13
            end
        end

        // direction register, cleared by reset
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                dir_reg[p] <= `PIO_DIR_RST;                 // R3
            end
            else
            begin
                dir_reg[p] <= dir_next[p];
            end
        end

        // output latch, reset leaves it alone
        always_ff @(posedge pclk)
        begin
            out_reg[p] <= out_next[p];                      // R4
        end

        // output bits show latch, input bits show pin
        assign rd_mix[p] = (out_reg[p] & dir_reg[p])      // R2 R6
                         | (pin_in[p] & ~dir_reg[p]);     // R7
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // latch drives continuously, enable follows direction
    assign first_port_lines_out  = out_reg[0];              // R14
    assign second_port_lines_out = out_reg[1];              // R14
    assign third_port_lines_out  = out_reg[2];              // R14
    // enable low releases the pin to high impedance
    assign first_port_lines_oe   = dir_reg[0];              // R2
    assign second_port_lines_oe  = dir_reg[1];              // R12
    assign third_port_lines_oe   = dir_reg[2];              // R12

    // ------------------------------------------------------------
    // read data and error
    // ------------------------------------------------------------
    // value captured at the setup edge, held for the access phase
    always_comb
    begin
        prdata_next  = prdata_reg;
        pslverr_next = pslverr_reg;
        if (psel && !penable)
        begin
            prdata_next  = `PIO_WORD_ZERO;
            pslverr_next = (sel == PIO_SEL_NONE);
            if (rd_setup)
            begin
                unique case (sel)
                    PIO_SEL_DATA_A: prdata_next[7:0] = rd_mix[0];
                    PIO_SEL_DATA_B: prdata_next[7:0] = rd_mix[1];
                    PIO_SEL_DATA_C: prdata_next[7:0] = rd_mix[2];
                    // fixed inputs, no direction
                    PIO_SEL_DATA_D: prdata_next[7:0] =
                                        input_only_port_lines;  // R9
                    // direction registers are write-only
                    PIO_SEL_DIR_A,
                    PIO_SEL_DIR_B,
                    PIO_SEL_DIR_C:  prdata_next[7:0] =
                                        `PIO_DIR_RDVAL;         // R8
                    PIO_SEL_NONE:   prdata_next[7:0] = 8'h00;
                endcase
            end
        end
    end

    // read data and error registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= `PIO_WORD_ZERO;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    // error only shown in the access phase
    assign pslverr = pslverr_reg & psel & penable;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // direction cleared right after reset
    dir_reset_zero_a: assert property ( // R3
        @(posedge pclk) $rose(presetn) |->
            (first_port_lines_oe == 8'h00)
            && (second_port_lines_oe == 8'h00)
            && (third_port_lines_oe == 8'h00))
        else $error("direction not cleared by reset");

    // direction write reaches the enables next cycle
    dir_write_oe_a: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `PIO_OFS_DIR_A) |=>
            first_port_lines_oe == $past(pwdata[7:0]))
        else $error("direction write not applied");

    // latch write lands whatever the direction
    latch_write_all_a: assert property ( // R5
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `PIO_OFS_DATA_B) |=>
            second_port_lines_out == $past(pwdata[7:0]))
        else $error("latch write lost bits");

    // driven pin follows its latch in the cycle after the write
    pin_follows_latch_a: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `PIO_OFS_DATA_C) |=>
            (third_port_lines_out & third_port_lines_oe)
            == ($past(pwdata[7:0]) & third_port_lines_oe))
        else $error("driven pin not updated");

    // readback mixes latch and pin per direction
    mixed_read_a: assert property ( // R6 R7
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == `PIO_OFS_DATA_A) ##1 (psel && penable)
        |-> prdata[7:0] == $past((out_reg[0] & dir_reg[0])
                               | (first_port_lines_in & ~dir_reg[0])))
        else $error("port read mix wrong");

    // direction registers read as ones
    dir_read_ones_a: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && (paddr == `PIO_OFS_DIR_A
                   || paddr == `PIO_OFS_DIR_B
                   || paddr == `PIO_OFS_DIR_C)) |=>
            prdata == 32'h000000FF)
        else $error("direction read not all ones");

    // input-only port reads the pins
    input_port_read_a: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == `PIO_OFS_DATA_D) |=>
            prdata[7:0] == $past(input_only_port_lines))
        else $error("input port read wrong");

    // released pins stay released until a direction write
    hiz_hold_a: assert property ( // R12
        @(posedge pclk) disable iff (!presetn)
        (second_port_lines_oe == 8'h00)
        && !(wr_en && paddr == `PIO_OFS_DIR_B) |=>
            second_port_lines_oe == 8'h00)
        else $error("driver enabled without direction write");

    // seven mapped registers answer without error
    mapped_no_err_a: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr <= `PIO_OFS_DIR_C
              && paddr[1:0] == 2'b00) |=>
            (pready && !pslverr))
        else $error("mapped register refused");

    // direction held unless its own register is written
    dir_hold_a: assert property ( // R13
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == `PIO_OFS_DIR_A) |=>
            $stable(first_port_lines_oe))
        else $error("direction changed without write");

    // unmapped places answer with an error
    unmapped_err_a: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && sel == PIO_SEL_NONE)
        ##1 (psel && penable) |-> pslverr)
        else $error("unmapped access not refused");

endmodule : pio_port_block

//--- verif/pio_pin_model.sv
// Purpose: board side of one bidirectional port
// Assumes: three-state pins, no pull-up or pull-down on the board
// Notes:   heavy_load lets the board overpower pins the block drives
`timescale 1ns/1ps

module pio_pin_model
(
    // block side of the pins
    input  wire logic [7:0] drv_val,
    input  wire logic [7:0] drv_en,
    // board side of the pins
    input  wire logic [7:0] board_val,
    input  wire logic       heavy_load,
    // resolved pin level
    output logic      [7:0] pin_level
);

    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // released bits show the board level, driven bits the block's while heavy_load is low
    always_comb
    begin
        if (heavy_load)
            pin_level = board_val;
        else
            pin_level = (drv_en & drv_val) | (~drv_en & board_val);
    end

endmodule : pio_pin_model

//--- verif/tb_pio_port_block.sv
// Purpose: self-checking bench of the parallel port block
// Assumes: apb master tasks, board modelled per bidirectional port
// Notes:   latches written before outputs are enabled
`timescale 1ns/1ps
`include "pio_defines.svh"

module tb_pio_port_block
    import pio_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic             pclk;       // bus clock
    logic             presetn;    // async reset
    logic             psel;       // apb select
    logic             penable;    // apb access phase
    logic             pwrite;     // apb direction
    logic [11:0]      paddr;      // apb address
    logic [31:0]      pwdata;     // apb write data
    logic [31:0]      prdata;     // apb read data
    logic             pready;     // apb ready
    logic             pslverr;    // apb error
    logic [2:0][7:0]  out_w;      // latch outputs per port
    logic [2:0][7:0]  oe_w;       // drive enables per port
    logic [2:0][7:0]  lvl;        // resolved pin levels
    logic [2:0][7:0]  brd;        // board levels
    logic [7:0]       in_only;    // input-only port pins
    logic             load;       // board overpowers pins
    int               n_mismatch; // mismatch count
    int               n_tests;    // comparison count
    localparam logic [2:0][7:0] LAT = {8'h96, 8'h3C, 8'hA5};

    // ------------------------------------------------------------
    // design and board
    // ------------------------------------------------------------
    pio_port_block u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .first_port_lines_in(lvl[0]), .first_port_lines_out(out_w[0]),
        .first_port_lines_oe(oe_w[0]), .second_port_lines_in(lvl[1]),
        .second_port_lines_out(out_w[1]), .second_port_lines_oe(oe_w[1]),
        .third_port_lines_in(lvl[2]), .third_port_lines_out(out_w[2]),
        .third_port_lines_oe(oe_w[2]), .input_only_port_lines(in_only)
    );

    for (genvar g = 0; g < 3; g++)
    begin : g_pin
        pio_pin_model u_pin (
            .drv_val(out_w[g]), .drv_en(oe_w[g]), .board_val(brd[g]),
            .heavy_load(load), .pin_level(lvl[g])
        );
    end

    // 50 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer, read data checked on reads, error on every transfer
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic [31:0] err);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            stop_test();
        end
        else
        begin
            if (!wr)
                chk(prdata, exp);
            chk({31'h00000000, pslverr}, err);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // reset held five cycles
    task automatic rst();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : rst

    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        brd = ~LAT;
        in_only = 8'hB7;
        load = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        rst();
        @(negedge pclk);
        for (int i = 0; i < 3; i++)
        begin
            chk({24'h000000, oe_w[i]}, 32'h00000000);
            apb(1'b0, `PIO_OFS_DIR_A + 12'(4*i), 0, 32'h000000FF, 0);
            // latch loaded first, upper bits ignored
            apb(1'b1, 12'(4*i), {24'hFFFFFF, LAT[i]}, 0, 0);
            @(negedge pclk);
            chk({24'h000000, out_w[i]}, {24'h000000, LAT[i]});
            apb(1'b0, 12'(4*i), 0, {24'h000000, ~LAT[i]}, 0);
            apb(1'b1, `PIO_OFS_DIR_A + 12'(4*i), 32'h0F, 0, 0);
            // stored direction must not show through a read
            apb(1'b0, `PIO_OFS_DIR_A + 12'(4*i), 0, 32'h000000FF, 0);
            @(negedge pclk);
            chk({24'h000000, oe_w[i]}, 32'h0000000F);
            chk({24'h000000, lvl[i]}, {24'h000000, LAT[i] & 8'h0F |
                ~LAT[i] & 8'hF0});
        end
        // board overpowers driven pins: outputs still read the latch
        @(posedge pclk);
        load <= 1'b1;
        for (int i = 0; i < 3; i++)
            apb(1'b0, 12'(4*i), 0, {24'h000000, LAT[i] & 8'h0F |
                ~LAT[i] & 8'hF0}, 0);
        load <= 1'b0;
        apb(1'b0, `PIO_OFS_DATA_D, 0, 32'h000000B7, 0);
        in_only <= 8'h48;
        apb(1'b0, `PIO_OFS_DATA_D, 0, 32'h00000048, 0);
        // unmapped place refused, nothing changes
        apb(1'b1, 12'h01C, 32'h000000FF, 0, 1);
        apb(1'b0, 12'h01C, 0, 0, 1);
        @(negedge pclk);
        chk({24'h000000, oe_w[0]}, 32'h0000000F);
        apb(1'b1, `PIO_OFS_DIR_A, 32'hFF, 0, 0);
        apb(1'b1, `PIO_OFS_DATA_A, 32'h5A, 0, 0);
        @(negedge pclk);
        chk({24'h000000, lvl[0]}, 32'h0000005A);
        // reset in mid-run: directions cleared, latches kept
        rst();
        @(negedge pclk);
        chk({8'h00, oe_w}, 32'h00000000);
        chk({8'h00, out_w}, {8'h00, LAT[2], LAT[1], 8'h5A});
        apb(1'b0, `PIO_OFS_DATA_A, 0, {24'h000000, ~LAT[0]}, 0);
        stop_test();
    end

endmodule : tb_pio_port_block
